// ### logic/bsbt_buf.sv
/*
  Two-entry word buffer with valid/ready on both sides.
  Assumes the drain side may stall; ready and valid come straight from flops.
*/
module bsbt_buf
  import bsbt_pkg::*;
#(
  parameter int W     = WORD_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready_r,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid_r,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign push     = in_valid && in_ready_r;
  assign pop      = out_valid_r && out_ready;
  assign cnt_nxt  = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_r[rd_ptr_r];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock) begin
      if (ce && push && wr_ptr_r == AW'(i)) begin
        mem_r[i] <= in_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      cnt_r       <= '0;
      in_ready_r  <= 1'b1;
      out_valid_r <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      cnt_r       <= cnt_nxt;
      in_ready_r  <= (cnt_nxt != FULL);
      out_valid_r <= (cnt_nxt != '0);
    end
  end
endmodule

// ### logic/bsbt_core.sv
/*
  Bulk-store block-transfer unit: takes a read or write issue, checks the
  whole block, then streams words between the bulk store and central memory.
  Assumes both stores answer commands in order on the processor clock; the
  three status pins are asynchronous and are synchronised here.
*/
// Function
// - wrong slot or no store: exit reloc base
// - read: bulk to memory, relocated starts
// - write: memory to bulk, same starts
// - negative word count is a range fault
// - fault: stop if policy set, else P+1
// - memory limit must exceed operand plus count
// - bulk limit minus end non-negative faults
// - word 7 at bulk limit faults
// - all checks before moving; fault moves nothing
// - error exit goes to lower half
// - parity error: finish block, then error exit
// - bank unavailable: immediate error exit
// - write to missing address: immediate error
// - read of missing address writes zeros
// - exchange waits for current record end
// - clean block end: P+1 then exchange
// - errored block end: lower half, exchange
// - unfinished block: save P, restart later
module bsbt_core
  import bsbt_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          start_valid,
  input  bsbt_start_t        start,
  output logic               busy_r,
  input  wire logic          bulk_fitted,
  input  wire logic          bank_unavail,
  input  wire logic          xchg_req,
  output logic               done_r,
  output bsbt_exit_t         exit_r,
  output logic               bulk_cmd_valid_r,
  output bsbt_bulk_cmd_t     bulk_cmd_r,
  input  wire logic          bulk_cmd_ready,
  input  wire logic          bulk_rsp_valid,
  input  bsbt_bulk_rsp_t     bulk_rsp,
  output logic               bulk_rsp_ready,
  output logic               mem_cmd_valid_r,
  output bsbt_mem_cmd_t      mem_cmd_r,
  input  wire logic          mem_cmd_ready,
  input  wire logic          mem_rsp_valid,
  input  wire logic [WORD_W-1:0] mem_rsp,
  output logic               mem_rsp_ready
);
  logic [NSYNC-1:0]   pin_in;
  logic [NSYNC-1:0]   pin_meta_r;
  logic [NSYNC-1:0]   pin_sync_r;
  bsbt_state_t        state_r;
  bsbt_start_t        op_r;
  bsbt_fault_t        fault_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   issued_r;
  logic [CNT_W-1:0]   moved_r;
  logic [BADDR_W-1:0] src_addr_r;
  logic [BADDR_W-1:0] dst_addr_r;
  logic [BADDR_W-1:0] rsp_addr_r;
  logic               err_r;
  logic               xpend_r;
  logic               fitted_s;
  logic               unavail_s;
  logic               xchg_s;
  logic               is_rd;
  logic               in_move;
  logic [CNT_W-1:0]   cnt_sum;
  logic [BADDR_W-1:0] bulk_start;
  logic [MADDR_W-1:0] mem_start;
  logic [BADDR_W-1:0] mem_start_ext;
  logic [BADDR_W:0]   bulk_end;
  logic               write_nonexist;
  logic               any_fault;
  logic               eval_go;
  logic               stop_issue;
  logic               src_v;
  logic               src_rdy;
  logic               src_load;
  logic               dst_v;
  logic               dst_rdy;
  logic               dst_fire;
  logic               dst_load;
  logic               bulk_load;
  logic               bulk_fire;
  logic               mem_load;
  logic               mem_fire;
  logic               buf_in_valid;
  logic               buf_in_ready_r;
  logic [WORD_W-1:0]  buf_in_data;
  logic               buf_out_valid_r;
  logic [WORD_W-1:0]  buf_out_data;
  logic               push;
  logic               rsp_hole;
  logic               rsp_parity;
  logic               block_end;
  logic               finish;
  bsbt_exit_kind_t    eval_kind;
  bsbt_exit_kind_t    end_kind;
  bsbt_exit_kind_t    done_kind;
  bsbt_exit_t         exit_nxt;
  bsbt_bulk_cmd_t     bulk_cmd_nxt;
  bsbt_mem_cmd_t      mem_cmd_nxt;

  // status pins come from another domain
  assign pin_in = {xchg_req, bank_unavail, bulk_fitted};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (srst) begin
        pin_meta_r[i] <= 1'b0;
        pin_sync_r[i] <= 1'b0;
      end else if (ce) begin
        pin_meta_r[i] <= pin_in[i];
        pin_sync_r[i] <= pin_meta_r[i];
      end
    end
  end
  assign fitted_s  = pin_sync_r[0];
  assign unavail_s = pin_sync_r[1];
  assign xchg_s    = pin_sync_r[2];

  bsbt_range_check u_check (
    .clock   (clock),
    .srst    (srst),
    .ce      (ce),
    .op      (op_r),
    .fault_r (fault_r)
  );

  assign is_rd   = (op_r.opcode == OP_BULK_READ);
  assign in_move = (state_r == S_MOVE);
  assign cnt_sum = op_r.count_index_register + op_r.k_const;
  assign bulk_start    = op_r.bulk_address_operand + op_r.bulk_reloc_base;
  assign mem_start     = op_r.memory_address_operand + op_r.memory_reloc_base;
  assign mem_start_ext = {{(BADDR_W-MADDR_W){1'b0}}, mem_start};
  assign bulk_end       = {1'b0, bulk_start} + {{(BADDR_W+1-CNT_W){1'b0}}, cnt_sum};
  assign write_nonexist = bulk_end > {1'b0, op_r.bulk_installed};
  assign any_fault      = |fault_r;

  // every check decided before any command
  assign eval_go = op_r.upper_pos && fitted_s && !any_fault && !unavail_s
                && !(!is_rd && write_nonexist);
  assign eval_kind = (!op_r.upper_pos || !fitted_s) ? BSBT_EXIT_RELOC
                   // policy bit picks stop or skip
                   : any_fault ? (op_r.oor_stop ? BSBT_EXIT_STOP : BSBT_EXIT_NEXT)
                   : unavail_s ? BSBT_EXIT_ERROR
                   : BSBT_EXIT_ERROR;

  // stop issuing at the record boundary
  assign stop_issue = xpend_r && (issued_r[REC_LOG-1:0] == '0);

  assign src_v   = is_rd ? bulk_cmd_valid_r : mem_cmd_valid_r;
  assign src_rdy = is_rd ? bulk_cmd_ready : mem_cmd_ready;
  assign dst_v   = is_rd ? mem_cmd_valid_r : bulk_cmd_valid_r;
  assign dst_rdy = is_rd ? mem_cmd_ready : bulk_cmd_ready;
  assign dst_fire = dst_v && dst_rdy;
  assign src_load = in_move && (!src_v || (src_v && src_rdy)) && (issued_r != cnt_r)
                 && !stop_issue;
  assign dst_load = (!dst_v || dst_fire) && buf_out_valid_r;
  assign bulk_load = is_rd ? src_load : dst_load;
  assign mem_load  = is_rd ? dst_load : src_load;
  assign bulk_fire = bulk_cmd_valid_r && bulk_cmd_ready;
  assign mem_fire  = mem_cmd_valid_r && mem_cmd_ready;

  assign bulk_cmd_nxt.write = !is_rd;
  assign bulk_cmd_nxt.addr  = is_rd ? src_addr_r : dst_addr_r;
  assign bulk_cmd_nxt.data  = buf_out_data;
  assign mem_cmd_nxt.write  = is_rd;
  assign mem_cmd_nxt.addr   = is_rd ? dst_addr_r[MADDR_W-1:0] : src_addr_r[MADDR_W-1:0];
  assign mem_cmd_nxt.data   = buf_out_data;

  // responses only land while a block is moving
  assign buf_in_valid = in_move && (is_rd ? bulk_rsp_valid : mem_rsp_valid);
  // words past the installed store read as zero
  assign rsp_hole     = is_rd && (rsp_addr_r >= op_r.bulk_installed);
  assign rsp_parity   = is_rd && bulk_rsp.parity_err;
  assign buf_in_data  = rsp_hole ? '0 : (is_rd ? bulk_rsp.data : mem_rsp);
  assign push         = buf_in_valid && buf_in_ready_r;
  assign bulk_rsp_ready = buf_in_ready_r;
  assign mem_rsp_ready  = buf_in_ready_r;

  bsbt_buf u_buf (
    .clock       (clock),
    .srst        (srst),
    .ce          (ce),
    .in_valid    (buf_in_valid),
    .in_ready_r  (buf_in_ready_r),
    .in_data     (buf_in_data),
    .out_valid_r (buf_out_valid_r),
    .out_ready   (dst_load),
    .out_data    (buf_out_data)
  );

  // block ends only after every issued word lands
  assign block_end = in_move && (moved_r == issued_r) && ((issued_r == cnt_r) || stop_issue);
  // short block restarts from the instruction
  assign end_kind  = (moved_r != cnt_r) ? BSBT_EXIT_RESTART
                   // errored end takes the lower half
                   : err_r ? BSBT_EXIT_ERROR : BSBT_EXIT_NEXT;
  assign done_kind = in_move ? end_kind : eval_kind;
  assign finish    = ((state_r == S_EVAL) && !eval_go) || block_end;

  assign exit_nxt.kind = done_kind;
  assign exit_nxt.addr = (done_kind == BSBT_EXIT_RELOC) ? op_r.memory_reloc_base
                       : (done_kind == BSBT_EXIT_NEXT) ? op_r.program_addr + 1'b1
                       : op_r.program_addr;
  // error exit runs the lower 30-bit half
  assign exit_nxt.lower_half = (done_kind == BSBT_EXIT_ERROR);
  assign exit_nxt.exchange   = in_move && (xpend_r || xchg_s);

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= S_IDLE;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      exit_r  <= '0;
      op_r    <= '0;
    end else if (ce) begin
      done_r <= finish;
      if (finish) exit_r <= exit_nxt;
      unique case (state_r)
        S_IDLE: begin
          if (start_valid) begin
            op_r    <= start;
            busy_r  <= 1'b1;
            state_r <= S_CHECK;
          end
        end
        S_CHECK: state_r <= S_EVAL;
        S_EVAL: begin
          state_r <= eval_go ? S_MOVE : S_IDLE;
          busy_r  <= eval_go;
        end
        S_MOVE: begin
          if (block_end) begin
            state_r <= S_IDLE;
            busy_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r      <= '0;
      issued_r   <= '0;
      moved_r    <= '0;
      src_addr_r <= '0;
      dst_addr_r <= '0;
      rsp_addr_r <= '0;
    end else if (ce) begin
      if (state_r == S_EVAL) begin
        cnt_r      <= cnt_sum;
        issued_r   <= '0;
        moved_r    <= '0;
        src_addr_r <= is_rd ? bulk_start : mem_start_ext;
        dst_addr_r <= is_rd ? mem_start_ext : bulk_start;
        rsp_addr_r <= bulk_start;
      end else begin
        if (src_load) src_addr_r <= src_addr_r + 1'b1;
        if (src_load) issued_r <= issued_r + 1'b1;
        if (dst_load) dst_addr_r <= dst_addr_r + 1'b1;
        if (push) rsp_addr_r <= rsp_addr_r + 1'b1;
        if (dst_fire) moved_r <= moved_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      err_r   <= 1'b0;
      xpend_r <= 1'b0;
    end else if (ce) begin
      // parity or hole marks the block, transfer goes on
      if (push && (rsp_parity || rsp_hole)) err_r <= 1'b1;
      else if (state_r == S_EVAL) err_r <= 1'b0;
      // a request arriving mid-transfer stays pending until idle
      if (in_move && xchg_s) xpend_r <= 1'b1;
      else if (state_r == S_IDLE) xpend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bulk_cmd_valid_r <= 1'b0;
      mem_cmd_valid_r  <= 1'b0;
      bulk_cmd_r       <= '0;
      mem_cmd_r        <= '0;
    end else if (ce) begin
      if (bulk_load) bulk_cmd_valid_r <= 1'b1;
      else if (bulk_fire) bulk_cmd_valid_r <= 1'b0;
      if (bulk_load) bulk_cmd_r <= bulk_cmd_nxt;
      if (mem_load) mem_cmd_valid_r <= 1'b1;
      else if (mem_fire) mem_cmd_valid_r <= 1'b0;
      if (mem_load) mem_cmd_r <= mem_cmd_nxt;
    end
  end

  logic [BADDR_W-1:0] rd_addr_exp;
  logic [MADDR_W-1:0] wr_addr_exp;
  assign rd_addr_exp = bulk_start + {{(BADDR_W-CNT_W){1'b0}}, issued_r} - 1'b1;
  assign wr_addr_exp = mem_start + issued_r - 1'b1;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_reloc_exit: assert property (
    done_r && exit_r.kind == BSBT_EXIT_RELOC |-> exit_r.addr == op_r.memory_reloc_base)
    else $error("reloc exit address wrong");
  a_bulk_read_addr: assert property (
    in_move && is_rd && bulk_cmd_valid_r |-> bulk_cmd_r.addr == rd_addr_exp)
    else $error("bulk read address off");
  a_mem_write_src: assert property (
    in_move && !is_rd && mem_cmd_valid_r |-> mem_cmd_r.addr == wr_addr_exp)
    else $error("memory source address off");
  a_count_sign: assert property (
    state_r == S_EVAL |-> fault_r.count_neg == cnt_sum[CNT_W-1])
    else $error("count sign fault mismatch");
  a_fault_policy: assert property (
    state_r == S_EVAL && ce && op_r.upper_pos && fitted_s && any_fault
    |=> done_r && exit_r.kind == (op_r.oor_stop ? BSBT_EXIT_STOP : BSBT_EXIT_NEXT))
    else $error("fault exit ignores policy");
  a_fault_no_move: assert property (
    state_r == S_EVAL && ce && any_fault
    |=> state_r == S_IDLE ##1 !bulk_cmd_valid_r && !mem_cmd_valid_r)
    else $error("data moved after fault");
  a_error_lower: assert property (
    done_r && exit_r.kind == BSBT_EXIT_ERROR
    |-> exit_r.lower_half && exit_r.addr == op_r.program_addr)
    else $error("error exit not lower half");
  a_whole_block: assert property (
    done_r && exit_r.kind == BSBT_EXIT_ERROR && moved_r != '0 |-> moved_r == cnt_r)
    else $error("error exit before block end");
  a_unavail_exit: assert property (
    state_r == S_EVAL && ce && op_r.upper_pos && fitted_s && !any_fault && unavail_s
    |=> done_r && exit_r.kind == BSBT_EXIT_ERROR)
    else $error("bank down not immediate");
  a_restart_record: assert property (
    done_r && exit_r.kind == BSBT_EXIT_RESTART
    |-> moved_r[REC_LOG-1:0] == '0 && exit_r.addr == op_r.program_addr && exit_r.exchange)
    else $error("restart not at record end");
  a_next_addr: assert property (
    done_r && exit_r.kind == BSBT_EXIT_NEXT |-> exit_r.addr == op_r.program_addr + 1'b1)
    else $error("next exit address wrong");

  c_read_done:  cover property (done_r && is_rd && exit_r.kind == BSBT_EXIT_NEXT && cnt_r > 2);
  c_write_done: cover property (done_r && !is_rd && exit_r.kind == BSBT_EXIT_NEXT && cnt_r > 2);
  c_restart:    cover property (done_r && exit_r.kind == BSBT_EXIT_RESTART && moved_r != '0);
  c_err_xchg:   cover property (done_r && exit_r.kind == BSBT_EXIT_ERROR && exit_r.exchange);
endmodule

// ### logic/bsbt_pkg.sv
/*
  Shared constants and carrier types of the bulk-store block-transfer unit.
  Assumes a single processor clock and a synchronous active-high reset.
*/
package bsbt_pkg;
  localparam int WORD_W    = 60;
  localparam int BADDR_W   = 24;
  localparam int MADDR_W   = 18;
  localparam int CNT_W     = 18;
  localparam int SEXT_W    = 36;
  localparam int REC_LOG   = 3;
  localparam int BUF_DEPTH = 2;
  localparam int NSYNC     = 3;
  localparam logic [2:0] OP_BULK_READ  = 3'h3;
  localparam logic [2:0] REC_LAST_WORD = 3'h7;

  typedef enum logic [2:0] {
    BSBT_EXIT_NEXT, BSBT_EXIT_ERROR, BSBT_EXIT_RELOC, BSBT_EXIT_STOP, BSBT_EXIT_RESTART
  } bsbt_exit_kind_t;

  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_EVAL, S_MOVE} bsbt_state_t;

  typedef struct packed {
    logic [2:0]         opcode;
    logic               upper_pos;
    logic               oor_stop;
    logic [CNT_W-1:0]   count_index_register;
    logic [CNT_W-1:0]   k_const;
    logic [BADDR_W-1:0] bulk_address_operand;
    logic [MADDR_W-1:0] memory_address_operand;
    logic [BADDR_W-1:0] bulk_reloc_base;
    logic [MADDR_W-1:0] memory_reloc_base;
    logic [BADDR_W-1:0] bulk_field_length;
    logic [MADDR_W-1:0] memory_field_length;
    logic [BADDR_W-1:0] bulk_installed;
    logic [MADDR_W-1:0] program_addr;
  } bsbt_start_t;

  typedef struct packed {
    bsbt_exit_kind_t    kind;
    logic [MADDR_W-1:0] addr;
    logic               lower_half;
    logic               exchange;
  } bsbt_exit_t;

  typedef struct packed {
    logic               write;
    logic [BADDR_W-1:0] addr;
    logic [WORD_W-1:0]  data;
  } bsbt_bulk_cmd_t;

  typedef struct packed {
    logic               write;
    logic [MADDR_W-1:0] addr;
    logic [WORD_W-1:0]  data;
  } bsbt_mem_cmd_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              parity_err;
  } bsbt_bulk_rsp_t;

  typedef struct packed {
    logic count_neg;
    logic mem_oor;
    logic bulk_oor;
    logic word7;
  } bsbt_fault_t;
endpackage

// ### logic/bsbt_range_check.sv
/*
  Range checker: word count sign, memory and bulk field limits, word-7 probe.
  Assumes its operand struct is stable for the cycle before the result is read.
*/
module bsbt_range_check
  import bsbt_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  srst,
  input  wire logic  ce,
  input  bsbt_start_t op,
  output bsbt_fault_t fault_r
);
  logic [CNT_W-1:0]   count;
  logic [MADDR_W:0]   mem_end;
  logic [WORD_W-1:0]  bulk_end;
  logic [WORD_W-1:0]  bulk_diff;
  logic [BADDR_W:0]   w7_addr;
  logic [BADDR_W:0]   x0_ext;
  logic [BADDR_W:0]   x0_end;
  bsbt_fault_t        fault_nxt;

  assign count   = op.count_index_register + op.k_const;
  assign mem_end = {1'b0, op.memory_address_operand} + {1'b0, count};
  assign bulk_end = {{(WORD_W-BADDR_W){1'b0}}, op.bulk_address_operand}
                  + {{(WORD_W-CNT_W){1'b0}}, count};
  assign bulk_diff = {{SEXT_W{op.bulk_field_length[BADDR_W-1]}}, op.bulk_field_length}
                   - bulk_end;
  assign w7_addr = {1'b0, op.bulk_field_length[BADDR_W-1:REC_LOG], REC_LAST_WORD};
  assign x0_ext  = {1'b0, op.bulk_address_operand};
  assign x0_end  = x0_ext + {{(BADDR_W+1-CNT_W){1'b0}}, count};

  assign fault_nxt.count_neg = count[CNT_W-1];
  assign fault_nxt.mem_oor   = !({1'b0, op.memory_field_length} > mem_end);
  assign fault_nxt.bulk_oor  = !bulk_diff[WORD_W-1];
  assign fault_nxt.word7     = (x0_ext <= w7_addr) && (w7_addr < x0_end);

  always_ff @(posedge clock) begin
    if (srst) begin
      fault_r <= '0;
    end else if (ce) begin
      fault_r <= fault_nxt;
    end
  end
endmodule

// ### test/bsbt_store_model.sv
/*
  Behavioural bulk store and central memory on the far side of the unit.
  Assumes in-order answers; the bench drives stall and the parity fault.
*/
module bsbt_store_model
  import bsbt_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         stall,
  input  wire logic         par_err,
  input  wire logic         bulk_cmd_valid,
  input  bsbt_bulk_cmd_t    bulk_cmd,
  output logic              bulk_cmd_ready,
  output logic              bulk_rsp_valid,
  output bsbt_bulk_rsp_t    bulk_rsp,
  input  wire logic         bulk_rsp_ready,
  input  wire logic         mem_cmd_valid,
  input  bsbt_mem_cmd_t     mem_cmd,
  output logic              mem_cmd_ready,
  output logic              mem_rsp_valid,
  output logic [WORD_W-1:0] mem_rsp,
  input  wire logic         mem_rsp_ready
);
  logic [WORD_W-1:0] bmem [int];
  logic [WORD_W-1:0] mmem [int];
  logic [WORD_W-1:0] bq [$];
  logic [WORD_W-1:0] mq [$];
  logic              tog = 0;
  int                nbw;
  int                nmw;
  function automatic logic [WORD_W-1:0] pat(int a);
    return {a[23:0], ~a[23:0], 12'h5a5};
  endfunction
  assign bulk_cmd_ready = !stall;
  assign mem_cmd_ready  = !stall;
  always @(posedge clock) begin
    tog <= ~tog;
    if (srst) begin
      bq.delete();
      mq.delete();
      nbw = 0;
      nmw = 0;
    end else begin
      if (bulk_rsp_valid && bulk_rsp_ready) void'(bq.pop_front());
      if (mem_rsp_valid && mem_rsp_ready) void'(mq.pop_front());
      if (bulk_cmd_valid && bulk_cmd_ready && bulk_cmd.write) begin
        bmem[bulk_cmd.addr] = bulk_cmd.data;
        nbw++;
      end else if (bulk_cmd_valid && bulk_cmd_ready)
        bq.push_back(bmem.exists(bulk_cmd.addr) ? bmem[bulk_cmd.addr] : pat(bulk_cmd.addr));
      if (mem_cmd_valid && mem_cmd_ready && mem_cmd.write) begin
        mmem[mem_cmd.addr] = mem_cmd.data;
        nmw++;
      end else if (mem_cmd_valid && mem_cmd_ready)
        mq.push_back(mmem.exists(mem_cmd.addr) ? mmem[mem_cmd.addr] : pat(mem_cmd.addr));
    end
    // answers change after the edge only, so the unit never races the queue update;
    // idle data toggles so a stale word is never mistaken for a fresh one
    bulk_rsp_valid <= bq.size() > 0;
    bulk_rsp       <= '{data: bq.size() > 0 ? bq[0] : {30{tog, ~tog}},
                        parity_err: par_err && bq.size() > 0};
    mem_rsp_valid  <= mq.size() > 0;
    mem_rsp        <= mq.size() > 0 ? mq[0] : {30{~tog, tog}};
  end
endmodule

// ### test/bulk_store_block_transfer_bench.sv
/*
  Self-checking bench of the block-transfer unit beside a store model.
  Assumes the model answers in order; exits are judged from exit_r.
*/
module bulk_store_block_transfer_bench
  import bsbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock = 0, srst = 1, start_valid = 0, fit = 1, bank = 0, xchg = 0;
  logic              stall = 0, par_err = 0, busy_r, done_r, bcv, bcr, brv, brr;
  logic              mcv, mcr, mrv, mrr;
  bsbt_start_t       st;
  bsbt_exit_t        exit_r;
  bsbt_bulk_cmd_t    bc;
  bsbt_bulk_rsp_t    br;
  bsbt_mem_cmd_t     mc;
  logic [WORD_W-1:0] mr;
  int                seed = 32'h65eb, n_mismatch = 0, n_tests = 0, cyc = 0, nt = 0, w, c;
  always #50 clock = ~clock;
  always @(negedge clock) stall <= ($random(seed) & 3) == 0;
  bsbt_core u_dut (.clock(clock), .srst(srst), .ce(1'b1), .start_valid(start_valid),
    .start(st), .busy_r(busy_r), .bulk_fitted(fit), .bank_unavail(bank), .xchg_req(xchg),
    .done_r(done_r), .exit_r(exit_r), .bulk_cmd_valid_r(bcv), .bulk_cmd_r(bc),
    .bulk_cmd_ready(bcr), .bulk_rsp_valid(brv), .bulk_rsp(br), .bulk_rsp_ready(brr),
    .mem_cmd_valid_r(mcv), .mem_cmd_r(mc), .mem_cmd_ready(mcr), .mem_rsp_valid(mrv),
    .mem_rsp(mr), .mem_rsp_ready(mrr));
  bsbt_store_model u_st (.clock(clock), .srst(srst), .stall(stall), .par_err(par_err),
    .bulk_cmd_valid(bcv), .bulk_cmd(bc), .bulk_cmd_ready(bcr), .bulk_rsp_valid(brv),
    .bulk_rsp(br), .bulk_rsp_ready(brr), .mem_cmd_valid(mcv), .mem_cmd(mc),
    .mem_cmd_ready(mcr), .mem_rsp_valid(mrv), .mem_rsp(mr), .mem_rsp_ready(mrr));
  function automatic logic [WORD_W-1:0] pat(int a);
    return {a[23:0], ~a[23:0], 12'h5a5};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // the ceiling is well above the longest run, and each go wait gives up after 600 cycles, so even a hang never reaches it
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(logic [63:0] seen, logic [63:0] exp, string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic base();
    st = '{opcode: OP_BULK_READ, upper_pos: 1'b1, count_index_register: 18'h3, k_const: 18'h1,
      bulk_address_operand: 24'h5, bulk_reloc_base: 24'h10, memory_address_operand: 18'h2,
      memory_reloc_base: 18'h64, bulk_field_length: 24'h80_0000, memory_field_length: 18'h40,
      bulk_installed: 24'hff_ffff, program_addr: 18'h200, default: '0};
  endtask
  task automatic go(bsbt_exit_kind_t k, logic [17:0] a);
    @(negedge clock);
    w = u_st.nmw;
    c = u_st.nbw;
    start_valid = 1;
    @(negedge clock);
    start_valid = 0;
    for (int n = 0; n < 600 && done_r !== 1'b1; n++) @(negedge clock);
    chk(exit_r.kind, k, "exit kind");
    if (k != BSBT_EXIT_STOP) chk(exit_r.addr, a, "exit addr");
    nt++;
    $display("test %0d done", nt);
  endtask
  initial begin
    base();
    repeat (3) @(negedge clock);
    srst = 0;
    repeat (3) @(negedge clock);
    st.upper_pos = 0;
    go(BSBT_EXIT_RELOC, 18'h64);
    base();
    fit = 0;
    repeat (3) @(negedge clock);
    go(BSBT_EXIT_RELOC, 18'h64);
    fit = 1;
    repeat (3) @(negedge clock);
    for (int i = 0; i < 2; i++) begin
      base();
      st.count_index_register = -18'h5;
      st.oor_stop = !i;
      go(i ? BSBT_EXIT_NEXT : BSBT_EXIT_STOP, 18'h201);
      chk(u_st.nmw - w, 0, "moved on fault");
    end
    for (int i = 0; i < 2; i++) begin
      base();
      st.memory_field_length = 18'h6 + i;
      go(BSBT_EXIT_NEXT, 18'h201);
      chk(u_st.nmw - w, i * 4, "words at limit");
    end
    base();
    st.bulk_field_length = 24'h100;
    go(BSBT_EXIT_NEXT, 18'h201);
    chk(u_st.nmw - w, 0, "bulk fault");
    base();
    st.bulk_field_length = 24'h8;
    st.bulk_address_operand = 0;
    st.count_index_register = 18'hf;
    go(BSBT_EXIT_NEXT, 18'h201);
    chk(u_st.nmw - w, 0, "word 7");
    base();
    st.count_index_register = $random(seed) & 7;
    go(BSBT_EXIT_NEXT, 18'h201);
    for (int i = 0; i <= st.count_index_register; i++)
      chk(u_st.mmem[102 + i], pat(21 + i), "read word");
    base();
    st.opcode = 3'h0;
    st.bulk_address_operand = 24'h40;
    st.memory_address_operand = 18'h1e;
    st.count_index_register = 18'h2;
    go(BSBT_EXIT_NEXT, 18'h201);
    for (int i = 0; i < 3; i++) chk(u_st.bmem[80 + i], pat(130 + i), "write word");
    base();
    bank = 1;
    repeat (3) @(negedge clock);
    go(BSBT_EXIT_ERROR, 18'h200);
    chk({exit_r.lower_half, 32'(u_st.nmw - w)}, {1'b1, 32'h0}, "bank down");
    bank = 0;
    st.opcode = 3'h0;
    st.bulk_installed = 24'h16;
    repeat (3) @(negedge clock);
    go(BSBT_EXIT_ERROR, 18'h200);
    chk(u_st.nbw - c, 0, "write missing");
    st.opcode = OP_BULK_READ;
    st.memory_address_operand = 18'h10;
    go(BSBT_EXIT_ERROR, 18'h200);
    chk(u_st.mmem[116], pat(21), "real word");
    chk(u_st.mmem[117], 0, "zero fill");
    base();
    par_err = 1;
    go(BSBT_EXIT_ERROR, 18'h200);
    chk(u_st.nmw - w, 4, "whole block");
    par_err = 0;
    xchg = 1;
    st.count_index_register = 18'h13;
    go(BSBT_EXIT_RESTART, 18'h200);
    chk({exit_r.exchange, 32'((u_st.nmw - w) % 8)}, {1'b1, 32'h0}, "record");
    xchg = 0;
    // one full record: the exchange waits for the block end, clean or errored
    for (int i = 0; i < 2; i++) begin
      base();
      par_err = i[0];
      xchg = 1;
      st.count_index_register = 18'h7;
      go(i ? BSBT_EXIT_ERROR : BSBT_EXIT_NEXT, i ? 18'h200 : 18'h201);
      chk({exit_r.exchange, 32'(u_st.nmw - w)}, {1'b1, 32'h8}, "end exchange");
      xchg = 0;
    end
    par_err = 0;
    final_report();
  end
endmodule
